// ---- logic/sdac_pkg.sv ----
// Package: offsets, field positions and codes for the converter control block
`default_nettype none
package sdac_pkg;
  localparam int SDAC_CHANNELS = 3;
  localparam logic [11:0] OFF_GLOBAL = 12'h100;
  localparam logic [11:0] OFF_VECTOR = 12'h110;
  localparam logic [11:0] OFF_CHAN_CTRL = 12'h120;
  localparam logic [11:0] OFF_CHAN_INPUT = 12'h130;
  localparam logic [11:0] OFF_CHAN_RESULT = 12'h140;
  localparam logic [11:0] OFF_CHAN_PRELOAD = 12'h150;
  localparam logic [11:0] OFF_CHAN_STRIDE = 12'h004;
  localparam int GC_LOW_POWER = 8;
  localparam int GC_DIV_LO = 6;
  localparam int GC_SRC_LO = 4;
  localparam int GC_MIDRAIL = 3;
  localparam int GC_REF = 2;
  localparam int GC_OVIE = 1;
  localparam logic [15:0] GC_WRITE_MASK = 16'h01FE;
  localparam int CC_SINGLE = 10;
  localparam int CC_OSR_LO = 8;
  localparam int CC_TOGGLE = 7;
  localparam int CC_HALF = 6;
  localparam int CC_OVF = 5;
  localparam int CC_FORMAT = 4;
  localparam int CC_IE = 3;
  localparam int CC_DONE = 2;
  localparam int CC_START = 1;
  localparam int CC_GROUP = 0;
  localparam logic [15:0] CC_WRITE_MASK = 16'h07FF;
  localparam int IC_DELAY_LO = 6;
  localparam int IC_GAIN_LO = 3;
  localparam logic [2:0] GAIN_LAST_VALID = 3'h5;
  localparam logic [15:0] VEC_NONE = 16'h0000;
  localparam logic [15:0] VEC_OVERFLOW = 16'h0002;
  localparam logic [15:0] VEC_CHAN_BASE = 16'h0004;
  localparam logic [15:0] VEC_CHAN_STEP = 16'h0002;
  localparam logic [1:0] SRC_MASTER = 2'h0;
  localparam logic [1:0] SRC_SUB_MAIN = 2'h1;
  localparam logic [1:0] SRC_AUX = 2'h2;
  localparam logic [1:0] SRC_TIMER = 2'h3;
  localparam logic [31:0] PSLVERR_DATA = 32'h00000000;
endpackage : sdac_pkg
`default_nettype wire

// ---- logic/sdac_chan_if.sv ----
// Interface between the register file and one channel's result tracker
`default_nettype none
interface sdac_chan_if;
  logic result_valid;
  logic [31:0] result_data;
  logic start;
  logic restart;
  logic [1:0] delay_field;
  logic result_read;
  logic done_clear;
  logic ovf_clear;
  logic done_flag;
  logic ovf_flag;
  logic [31:0] held_result;
  modport regs (output start, restart, delay_field, result_read, done_clear, ovf_clear,
    input done_flag, ovf_flag, held_result);
  modport chan (input result_valid, result_data, start, restart, delay_field, result_read,
    done_clear, ovf_clear, output done_flag, ovf_flag, held_result);
endinterface : sdac_chan_if
`default_nettype wire

// ---- logic/sdac_clock_gen.sv ----
// Converter clock source select and divider
`default_nettype none
module sdac_clock_gen
  import sdac_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] clock_in,
  input wire logic [1:0] clock_source_field,
  input wire logic [1:0] clock_divide_field,
  output logic conv_clock_tick
);
  import sdac_pkg::*;
  typedef struct packed {
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic last;
    logic [2:0] count;
    logic tick;
  } sdac_cg_type;
  sdac_cg_type r;
  sdac_cg_type next_r;
  logic sel;
  logic rise;
  logic [2:0] limit;
  always_comb begin
    next_r = r;
    next_r.sync1 = clock_in;
    next_r.sync2 = r.sync1;
    sel = r.sync2[clock_source_field];
    rise = sel && !r.last;
    next_r.last = sel;
    limit = 3'((4'h1 << clock_divide_field) - 4'h1);
    next_r.tick = 1'b0;
    if (rise) begin
      if (r.count >= limit) begin
        next_r.count = 3'h0;
        next_r.tick = 1'b1;
      end else begin
        next_r.count = r.count + 3'h1;
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
  assign conv_clock_tick = r.tick;
endmodule : sdac_clock_gen
`default_nettype wire

// ---- logic/sdac_chan_track.sv ----
// One channel: result holding, done and overflow flags, first interrupt delay
`default_nettype none
module sdac_chan_track
  import sdac_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  sdac_chan_if.chan ch
);
  import sdac_pkg::*;
  typedef struct packed {
    logic [31:0] result;
    logic done;
    logic ovf;
    logic unread;
    logic [2:0] skip;
  } sdac_ct_type;
  sdac_ct_type r;
  sdac_ct_type next_r;
  always_comb begin
    next_r = r;
    if (ch.start || ch.restart) begin
      next_r.skip = 3'(3'h3 - {1'b0, ch.delay_field});
    end
    if (ch.result_read) begin
      next_r.unread = 1'b0;
    end
    if (ch.done_clear || ch.result_read) begin
      next_r.done = 1'b0;
    end
    if (ch.ovf_clear) begin
      next_r.ovf = 1'b0;
    end
    if (ch.result_valid) begin
      next_r.result = ch.result_data;
      next_r.unread = 1'b1;
      if (r.skip != 3'h0 && !(ch.start || ch.restart)) begin
        next_r.skip = r.skip - 3'h1;
      end else if (r.skip == 3'h0) begin
        next_r.done = 1'b1;
        if (r.unread && !ch.result_read) begin
          next_r.ovf = 1'b1;
        end
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
  assign ch.done_flag = r.done;
  assign ch.ovf_flag = r.ovf;
  assign ch.held_result = r.result;
endmodule : sdac_chan_track
`default_nettype wire

// ---- logic/sdac_control.sv ----
// Register file and control for a three-channel sigma-delta converter
//
// Our own choices: the APB register port and the placing of the registers.
`default_nettype none
module sdac_control
  import sdac_pkg::*;
#(
  parameter int CHANNELS = SDAC_CHANNELS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic global_irq_enable,
  input wire logic [3:0] clock_in,
  input wire logic [CHANNELS-1:0] result_valid,
  input wire logic [CHANNELS*32-1:0] result_data,
  output logic conv_clock_tick,
  output logic low_power_select,
  output logic reference_on,
  output logic midrail_buffer_on,
  output logic [CHANNELS-1:0] channel_run,
  output logic [CHANNELS-1:0] single_conversion_select,
  output logic [CHANNELS*2-1:0] oversampling_ratio_field,
  output logic [CHANNELS-1:0] result_format_select,
  output logic [CHANNELS-1:0] channel_group_link,
  output logic [CHANNELS*3-1:0] preamp_gain_field,
  output logic [CHANNELS-1:0] gain_reserved,
  output logic [CHANNELS*3-1:0] input_pair_select,
  output logic [CHANNELS-1:0] temp_sensor_select,
  output logic [CHANNELS-1:0] offset_short_select,
  output logic [CHANNELS*8-1:0] filter_preload,
  output logic [CHANNELS-1:0] filter_preload_load,
  output logic irq
);
  import sdac_pkg::*;

  typedef struct packed {
    logic [15:0] global_ctrl;
    logic [CHANNELS-1:0][15:0] chan_ctrl;
    logic [CHANNELS-1:0][7:0] chan_input;
    logic [CHANNELS-1:0][7:0] chan_preload;
    logic [CHANNELS-1:0] run;
    logic [CHANNELS-1:0] load;
    logic [31:0] rdata;
    logic err;
  } sdac_ctl_type;

  sdac_ctl_type r;
  sdac_ctl_type next_r;

  logic [CHANNELS-1:0] done_flag;
  logic [CHANNELS-1:0] ovf_flag;
  logic [CHANNELS-1:0][31:0] held;
  logic [CHANNELS-1:0] start_pulse;
  logic [CHANNELS-1:0] restart_pulse;
  logic [CHANNELS-1:0] read_pulse;
  logic [CHANNELS-1:0] done_clr;
  logic [CHANNELS-1:0] ovf_clr;
  logic [15:0] vector;
  logic access;

  // Channel register index from an address in a channel block
  function automatic int chan_index(input logic [11:0] addr, input logic [11:0] base);
    logic [11:0] diff;
    diff = addr - base;
    if (addr < base || diff[1:0] != 2'h0 || diff >= 12'(CHANNELS * 4)) begin
      return -1;
    end
    return int'(diff[11:2]);
  endfunction : chan_index

  // Apply byte strobes over a 16-bit register
  function automatic logic [15:0] strobe16(input logic [15:0] old, input logic [31:0] wd,
      input logic [3:0] st);
    logic [15:0] v;
    v = old;
    if (st[0]) begin
      v[7:0] = wd[7:0];
    end
    if (st[1]) begin
      v[15:8] = wd[15:8];
    end
    return v;
  endfunction : strobe16

  sdac_clock_gen u_clock_gen (
    .pclk(pclk),
    .presetn(presetn),
    .clock_in(clock_in),
    .clock_source_field(r.global_ctrl[GC_SRC_LO +: 2]),
    .clock_divide_field(r.global_ctrl[GC_DIV_LO +: 2]),
    .conv_clock_tick(conv_clock_tick)
  );

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_chan
      sdac_chan_if cif ();
      assign cif.result_valid = result_valid[g];
      assign cif.result_data = result_data[g*32 +: 32];
      assign cif.start = start_pulse[g];
      assign cif.restart = restart_pulse[g];
      assign cif.delay_field = r.chan_input[g][IC_DELAY_LO +: 2];
      assign cif.result_read = read_pulse[g];
      assign cif.done_clear = done_clr[g];
      assign cif.ovf_clear = ovf_clr[g];
      assign done_flag[g] = cif.done_flag;
      assign ovf_flag[g] = cif.ovf_flag;
      assign held[g] = cif.held_result;
      sdac_chan_track u_track (
        .pclk(pclk),
        .presetn(presetn),
        .ch(cif.chan)
      );
      assign single_conversion_select[g] = r.chan_ctrl[g][CC_SINGLE];
      assign oversampling_ratio_field[g*2 +: 2] = r.chan_ctrl[g][CC_OSR_LO +: 2];
      assign result_format_select[g] = r.chan_ctrl[g][CC_FORMAT];
      assign channel_group_link[g] = (g < CHANNELS - 1) ? r.chan_ctrl[g][CC_GROUP] : 1'b0;
      assign preamp_gain_field[g*3 +: 3] = r.chan_input[g][IC_GAIN_LO +: 3];
      assign gain_reserved[g] = r.chan_input[g][IC_GAIN_LO +: 3] > GAIN_LAST_VALID;
      assign input_pair_select[g*3 +: 3] = r.chan_input[g][2:0];
      assign temp_sensor_select[g] = r.chan_input[g][2:0] == 3'h6;
      assign offset_short_select[g] = r.chan_input[g][2:0] == 3'h7;
      assign filter_preload[g*8 +: 8] = r.chan_preload[g];
    end
  endgenerate

  // Highest priority enabled source; disabled sources are invisible
  always_comb begin
    vector = VEC_NONE;
    for (int i = CHANNELS - 1; i >= 0; i--) begin
      if (done_flag[i] && r.chan_ctrl[i][CC_IE]) begin
        vector = 16'(VEC_CHAN_BASE + VEC_CHAN_STEP * 16'(i));
      end
    end
    if (r.global_ctrl[GC_OVIE] && |ovf_flag) begin
      vector = VEC_OVERFLOW;
    end
  end

  assign access = psel && penable;

  always_comb begin
    int ci;
    int ii;
    int ri;
    int pi;
    logic [15:0] w16;
    logic [15:0] cc;
    ci = chan_index(paddr, OFF_CHAN_CTRL);
    ii = chan_index(paddr, OFF_CHAN_INPUT);
    ri = chan_index(paddr, OFF_CHAN_RESULT);
    pi = chan_index(paddr, OFF_CHAN_PRELOAD);
    w16 = 16'h0000;
    cc = 16'h0000;
    next_r = r;
    next_r.load = '0;
    start_pulse = '0;
    restart_pulse = '0;
    read_pulse = '0;
    done_clr = '0;
    ovf_clr = '0;
    for (int k = 0; k < CHANNELS; k++) begin
      if (r.run[k] && r.chan_ctrl[k][CC_SINGLE] && result_valid[k]) begin
        next_r.run[k] = 1'b0;
        next_r.chan_ctrl[k][CC_START] = 1'b0;
      end
    end
    if (access) begin
      next_r.err = 1'b0;
      next_r.rdata = 32'h00000000;
      if (pwrite) begin
        if (paddr == OFF_GLOBAL) begin
          w16 = strobe16(r.global_ctrl, pwdata, pstrb);
          next_r.global_ctrl = w16 & GC_WRITE_MASK;
        end else if (ci >= 0) begin
          cc = strobe16(r.chan_ctrl[ci], pwdata, pstrb) & CC_WRITE_MASK;
          cc[CC_DONE] = cc[CC_DONE] & r.chan_ctrl[ci][CC_DONE];
          cc[CC_OVF] = cc[CC_OVF] & r.chan_ctrl[ci][CC_OVF];
          done_clr[ci] = pstrb[0] && !pwdata[CC_DONE];
          ovf_clr[ci] = pstrb[0] && !pwdata[CC_OVF];
          next_r.chan_ctrl[ci] = cc;
          if (pstrb[0] && pwdata[CC_START]) begin
            start_pulse[ci] = 1'b1;
            next_r.run[ci] = 1'b1;
          end else if (pstrb[0]) begin
            next_r.run[ci] = 1'b0;
          end
        end else if (ii >= 0) begin
          if (pstrb[0]) begin
            next_r.chan_input[ii] = pwdata[7:0];
            restart_pulse[ii] = pwdata[5:0] != r.chan_input[ii][5:0];
          end
        end else if (pi >= 0) begin
          if (pstrb[0]) begin
            next_r.chan_preload[pi] = pwdata[7:0];
            next_r.load[pi] = 1'b1;
          end
        end else if (paddr != OFF_VECTOR && ri < 0) begin
          next_r.err = 1'b1;
        end
      end else begin
        if (paddr == OFF_GLOBAL) begin
          next_r.rdata = {16'h0000, r.global_ctrl};
        end else if (paddr == OFF_VECTOR) begin
          next_r.rdata = {16'h0000, vector};
        end else if (ci >= 0) begin
          cc = r.chan_ctrl[ci];
          cc[CC_DONE] = done_flag[ci];
          cc[CC_OVF] = ovf_flag[ci];
          next_r.rdata = {16'h0000, cc};
        end else if (ii >= 0) begin
          next_r.rdata = {24'h000000, r.chan_input[ii]};
        end else if (pi >= 0) begin
          next_r.rdata = {24'h000000, r.chan_preload[pi]};
        end else if (ri >= 0) begin
          next_r.rdata = {16'h0000, r.chan_ctrl[ri][CC_HALF] ? held[ri][15:0] : held[ri][31:16]};
          read_pulse[ri] = 1'b1;
          if (r.chan_ctrl[ri][CC_TOGGLE]) begin
            next_r.chan_ctrl[ri][CC_HALF] = !r.chan_ctrl[ri][CC_HALF];
          end
        end else begin
          next_r.err = 1'b1;
          next_r.rdata = PSLVERR_DATA;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // Zero-wait access phase; read data is combinational off next_r, the value about to be registered
  assign pready = 1'b1;
  always_comb begin
    prdata = 32'h00000000;
    pslverr = 1'b0;
    if (access) begin
      prdata = next_r.rdata;
      pslverr = next_r.err;
    end
  end

  assign low_power_select = r.global_ctrl[GC_LOW_POWER];
  assign reference_on = r.global_ctrl[GC_REF];
  assign midrail_buffer_on = r.global_ctrl[GC_MIDRAIL];
  assign channel_run = r.run;
  assign filter_preload_load = r.load;
  assign irq = global_irq_enable && (vector != VEC_NONE);

endmodule : sdac_control
`default_nettype wire

// ---- dv/sdac_control_props.sv ----
// Concurrent checks on the converter control block ports
`default_nettype none
module sdac_control_props
  import sdac_pkg::*;
#(
  parameter int CHANNELS = SDAC_CHANNELS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic global_irq_enable,
  input wire logic irq,
  input wire logic conv_clock_tick,
  input wire logic low_power_select,
  input wire logic reference_on,
  input wire logic midrail_buffer_on,
  input wire logic [CHANNELS-1:0] single_conversion_select,
  input wire logic [CHANNELS-1:0] result_format_select,
  input wire logic [CHANNELS-1:0] channel_group_link,
  input wire logic [CHANNELS*3-1:0] preamp_gain_field,
  input wire logic [CHANNELS-1:0] gain_reserved,
  input wire logic [CHANNELS*3-1:0] input_pair_select,
  input wire logic [CHANNELS-1:0] temp_sensor_select,
  input wire logic [CHANNELS-1:0] offset_short_select,
  input wire logic [CHANNELS*8-1:0] filter_preload,
  input wire logic [CHANNELS-1:0] filter_preload_load
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  assign acc = psel && penable;
  chk_irq_needs_gie: assert property (!global_irq_enable |-> !irq)
    else $error("irq raised without global enable");
  chk_global_write: assert property (acc && pwrite && paddr == OFF_GLOBAL |=>
    low_power_select == $past(pwdata[8]) && reference_on == $past(pwdata[2]) && midrail_buffer_on == $past(pwdata[3]))
    else $error("global control outputs not updated");
  chk_chan_write: assert property (acc && pwrite && paddr == OFF_CHAN_CTRL |=>
    single_conversion_select[0] == $past(pwdata[10]) && result_format_select[0] == $past(pwdata[4]))
    else $error("channel mode outputs not updated");
  chk_preload_write: assert property (acc && pwrite && paddr == OFF_CHAN_PRELOAD |=>
    filter_preload[7:0] == $past(pwdata[7:0]))
    else $error("preload value not updated");
  chk_preload_pulse: assert property (acc && pwrite && paddr == OFF_CHAN_PRELOAD |=>
    filter_preload_load[0])
    else $error("preload load pulse missing");
  chk_last_group: assert property (channel_group_link[CHANNELS-1] == 1'b0)
    else $error("last channel grouped");
  chk_gain_reserved: assert property (gain_reserved[0] == (preamp_gain_field[2:0] > 3'h5))
    else $error("gain reserved decode wrong");
  chk_temp_decode: assert property (temp_sensor_select[0] == (input_pair_select[2:0] == 3'h6))
    else $error("temperature select decode wrong");
  chk_short_decode: assert property (offset_short_select[0] == (input_pair_select[2:0] == 3'h7))
    else $error("shorted input decode wrong");
  chk_vector_shape: assert property (acc && !pwrite && paddr == OFF_VECTOR |->
    prdata[31:5] == 27'h0 && prdata[0] == 1'b0 && prdata[4:1] <= 4'h4)
    else $error("vector value out of range");
  chk_tick_pulse: assert property (conv_clock_tick |=> !conv_clock_tick)
    else $error("converter tick longer than one cycle");
  chk_idle_rdata: assert property (!acc |-> prdata == 32'h0 && !pslverr)
    else $error("read data outside access phase");
  cov_irq: cover property ($rose(irq));
  cov_err: cover property (acc && pslverr);
  cov_tick: cover property (conv_clock_tick);
endmodule : sdac_control_props
bind sdac_control sdac_control_props #(.CHANNELS(CHANNELS)) u_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pslverr(pslverr), .global_irq_enable(global_irq_enable), .irq(irq), .conv_clock_tick(conv_clock_tick),
  .low_power_select(low_power_select), .reference_on(reference_on), .midrail_buffer_on(midrail_buffer_on),
  .single_conversion_select(single_conversion_select), .result_format_select(result_format_select),
  .channel_group_link(channel_group_link), .preamp_gain_field(preamp_gain_field), .gain_reserved(gain_reserved),
  .input_pair_select(input_pair_select), .temp_sensor_select(temp_sensor_select),
  .offset_short_select(offset_short_select), .filter_preload(filter_preload),
  .filter_preload_load(filter_preload_load));
`default_nettype wire

// ---- dv/sdac_control_tb.sv ----
// Self-checking bench for the converter control block
`default_nettype none
module sdac_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sdac_pkg::*;
  `define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("[FAIL] %0t got %0h exp %0h", $time, (g), (e)); end end
  logic pclk = 1'b0, presetn, psel, penable, pwrite, pready, pslverr, global_irq_enable, irq;
  logic conv_clock_tick, low_power_select, reference_on, midrail_buffer_on;
  logic [2:0] result_valid, channel_run, single_conversion_select, result_format_select, channel_group_link;
  logic [2:0] gain_reserved, temp_sensor_select, offset_short_select;
  logic [3:0] clock_in, pstrb;
  logic [5:0] oversampling_ratio_field;
  logic [8:0] preamp_gain_field, input_pair_select;
  logic [11:0] paddr;
  logic [23:0] filter_preload;
  logic [31:0] pwdata, prdata, seed, r, r2;
  logic [32:0] got, want;
  logic [95:0] result_data;
  logic [32:0] exp_q[$];
  int fail_count, n_checks, ticks;
  sdac_control dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .global_irq_enable(global_irq_enable), .clock_in(clock_in), .result_valid(result_valid),
    .result_data(result_data), .conv_clock_tick(conv_clock_tick), .low_power_select(low_power_select),
    .reference_on(reference_on), .midrail_buffer_on(midrail_buffer_on), .channel_run(channel_run),
    .single_conversion_select(single_conversion_select), .oversampling_ratio_field(oversampling_ratio_field),
    .result_format_select(result_format_select), .channel_group_link(channel_group_link),
    .preamp_gain_field(preamp_gain_field), .gain_reserved(gain_reserved), .input_pair_select(input_pair_select),
    .temp_sensor_select(temp_sensor_select), .offset_short_select(offset_short_select),
    .filter_preload(filter_preload), .filter_preload_load(), .irq(irq));
  always #2 pclk = ~pclk;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic summarize();
    if (fail_count == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    exp_q.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      fail_count++;
      summarize();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 33'h0);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0, {1'b0, e});
  endtask : rd
  task automatic res(input logic [2:0] m, input logic [31:0] d);
    result_valid <= m;
    result_data <= {3{d}};
    @(posedge pclk);
    result_valid <= 3'h0;
    @(posedge pclk);
  endtask : res
  // Every completed transfer is matched against the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready) begin
      got = {pslverr, pwrite ? 32'h0 : prdata};
      if (exp_q.size() == 0) begin
        fail_count++;
      end else begin
        want = exp_q.pop_front();
        `CHK(got, want)
      end
    end
    if (conv_clock_tick === 1'b1) ticks++;
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, result_valid, result_data, clock_in} = '0;
    {presetn, global_irq_enable, pstrb, seed} = {1'b0, 1'b1, 4'hF, 32'h00000025};
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(OFF_GLOBAL, 32'h0);
    rd(OFF_VECTOR, 32'h0);
    rd(OFF_CHAN_CTRL, 32'h0);
    xfer(1'b0, 12'h200, 32'h0, 33'h100000000);
    wr(OFF_GLOBAL, 32'h0000FFFF);
    rd(OFF_GLOBAL, 32'h000001FE);
    `CHK({low_power_select, reference_on, midrail_buffer_on}, 3'h7)
    for (int c = 0; c < 4; c++) begin
      wr(OFF_GLOBAL, 32'((c << 6) | (c << 4)));
      ticks = 0;
      repeat (16) begin
        clock_in[c] <= 1'b1;
        repeat (3) @(posedge pclk);
        clock_in[c] <= 1'b0;
        repeat (3) @(posedge pclk);
      end
      repeat (10) @(posedge pclk);
      `CHK(ticks, 16 >> c)
    end
    wr(OFF_CHAN_CTRL, 32'h00000711);
    rd(OFF_CHAN_CTRL, 32'h00000711);
    `CHK({single_conversion_select[0], oversampling_ratio_field[1:0], result_format_select[0]}, 4'hF)
    `CHK(channel_group_link[0], 1'b1)
    wr(OFF_CHAN_CTRL + 12'h008, 32'h1);
    `CHK(channel_group_link[2], 1'b0)
    for (int c = 0; c < 8; c++) begin
      wr(OFF_CHAN_INPUT + 12'h004, 32'((c << 3) | c));
      rd(OFF_CHAN_INPUT + 12'h004, 32'((c << 3) | c));
      `CHK({gain_reserved[1], temp_sensor_select[1], offset_short_select[1]}, {c > 5, c == 6, c == 7})
      `CHK({preamp_gain_field[5:3], input_pair_select[5:3]}, 6'((c << 3) | c))
    end
    for (int k = 0; k < 3; k++) begin
      r = rnd() >> 24;
      wr(OFF_CHAN_PRELOAD + 12'(4 * k), r);
      rd(OFF_CHAN_PRELOAD + 12'(4 * k), r);
      `CHK(filter_preload[8 * k +: 8], r[7:0])
    end
    wr(OFF_CHAN_INPUT, 32'h000000C0);
    wr(OFF_CHAN_CTRL, 32'h0000008A);
    r = rnd();
    res(3'h1, r);
    rd(OFF_CHAN_CTRL, 32'h0000008E);
    rd(OFF_VECTOR, 32'h4);
    `CHK(irq, 1'b1)
    rd(OFF_CHAN_CTRL, 32'h0000008E);
    rd(OFF_CHAN_RESULT, {16'h0, r[31:16]});
    rd(OFF_CHAN_CTRL, 32'h000000CA);
    rd(OFF_CHAN_RESULT, {16'h0, r[15:0]});
    rd(OFF_CHAN_CTRL, 32'h0000008A);
    rd(OFF_VECTOR, 32'h0);
    r = rnd();
    r2 = rnd();
    res(3'h1, r);
    res(3'h1, r2);
    rd(OFF_CHAN_CTRL, 32'h000000AE);
    rd(OFF_VECTOR, 32'h4);
    wr(OFF_GLOBAL, 32'h2);
    rd(OFF_VECTOR, 32'h2);
    wr(OFF_VECTOR, 32'h0000FFFF);
    rd(OFF_CHAN_RESULT, {16'h0, r2[31:16]});
    rd(OFF_CHAN_CTRL, 32'h000000EA);
    wr(OFF_CHAN_CTRL, 32'h0000008A);
    rd(OFF_CHAN_CTRL, 32'h0000008A);
    rd(OFF_VECTOR, 32'h0);
    // First sample of a single conversion must raise the flag
    wr(OFF_CHAN_INPUT + 12'h004, 32'h000000C0);
    wr(OFF_CHAN_CTRL + 12'h004, 32'h0000040A);
    `CHK(channel_run[1], 1'b1)
    res(3'h2, rnd());
    rd(OFF_CHAN_CTRL + 12'h004, 32'h0000040C);
    `CHK(channel_run[1], 1'b0)
    rd(OFF_VECTOR, 32'h6);
    wr(OFF_CHAN_INPUT + 12'h008, 32'h0);
    wr(OFF_CHAN_CTRL + 12'h008, 32'h0000000A);
    repeat (3) res(3'h4, rnd());
    rd(OFF_CHAN_CTRL + 12'h008, 32'h0000000A);
    // Fourth sample lands on an unread third one
    res(3'h4, rnd());
    rd(OFF_CHAN_CTRL + 12'h008, 32'h0000002E);
    rd(OFF_VECTOR, 32'h2);
    `CHK(irq, 1'b1)
    global_irq_enable <= 1'b0;
    @(posedge pclk);
    `CHK(irq, 1'b0)
    summarize();
  end
endmodule : sdac_control_tb
`default_nettype wire
